// file: hdl/reset_sleep_watchdog_control.sv
`default_nettype none

// Functional notes
// RULE1 - Reset delay timer runs from the on-chip clock whenever powered. The code counts it down only in the hold state.
// RULE2 - Core held in reset while the reset delay timer runs.
// RULE3 - Delay after reset pin high: 18 ms after power-on, 10 us otherwise.
// RULE4 - Power-on, reset pin, watchdog expiry and pin wake start the delay.
// RULE5 - Watchdog counts on a clock kept running while the core sleeps.
// RULE6 - Watchdog expiry resets the device in run and wakes it from sleep.
// RULE7 - Watchdog expiry reset clears the active-low expiry flag, status bit 4.
// RULE8 - Watchdog enable fuse at 0 disables the watchdog for good.
// RULE9 - Watchdog base period 18 ms, prescaler up to 1:128 when assigned.
// RULE10 - Watchdog clear command resets counter and assigned prescaler.
// RULE11 - Sleep command resets watchdog counter and assigned prescaler.
// RULE12 - Sleep entry: watchdog runs, bit 4 set, bit 3 cleared, oscillator off.
// RULE13 - Pins keep their drive state throughout sleep.
// RULE14 - Watchdog reset never drives the reset pin low.
// RULE15 - Sleep ends by reset pin, watchdog, pin change or comparator change.
// RULE16 - Power-down flag set on power-up, cleared by the sleep command.
// RULE17 - Pin wake flag marks a change on pins 0, 1 or 3 in sleep.
// RULE18 - Comparator wake flag marks a comparator change in sleep.
// RULE19 - Pin change compared with pins latched at the last port access.
// RULE20 - Watchdog counter cleared on every wake from sleep.
// RULE21 - Cause flags hold until a reset; reset pin pulse leaves them alone. In sleep the code clears both wake flags on a reset pin pulse.
// RULE22 - Reset pin enable fuse at 1 makes the pin an external reset.
module reset_sleep_watchdog_control #(
    parameter int unsigned DRT_POR_CYCLES  = rsw_pkg::DRT_POR_CYC,
    parameter int unsigned WDT_BASE_CYCLES = rsw_pkg::WDT_BASE_CYC
) (
    input  wire logic             SYS_CLK,
    input  wire logic             RSTN,
    input  wire logic [1:0]       ADDR,
    input  wire logic [7:0]       WDATA,
    input  wire logic             WR,
    input  wire logic             RD,
    output var  logic [7:0]       RDATA,
    input  wire logic             RESET_PIN,
    output var  logic             RESET_PIN_OUT,
    output var  logic             RESET_PIN_OE_N,
    input  wire logic             RESET_PIN_FUSE,
    input  wire logic             WATCHDOG_FUSE,
    input  wire logic [3:0]       PORT_IN,
    input  wire logic             CMP_OUT,
    input  wire logic             CMP_WAKE_EN,
    input  wire logic [3:0]       CORE_OUT,
    input  wire logic [3:0]       CORE_OE_N,
    output var  logic [3:0]       PORT_OUT,
    output var  logic [3:0]       PORT_OE_N,
    output var  logic             CORE_RESET,
    output var  logic             OSC_DRIVE_EN,
    output var  logic             SLEEPING,
    output var  rsw_pkg::option_s OPTION
);

    function automatic rsw_pkg::ps_t ps_limit(input logic [2:0] rate);
        logic [7:0] full;
        full = 8'h01 << rate;
        ps_limit = rsw_pkg::ps_t'(full - 8'h01);
    endfunction

    function automatic logic access(input logic strobe, input logic [1:0] addr,
                                    input logic [1:0] target);
        access = strobe && (addr == target);
    endfunction

    localparam rsw_pkg::cnt_t DRT_POR_LOAD  = rsw_pkg::cnt_t'(DRT_POR_CYCLES - 1);
    localparam rsw_pkg::cnt_t DRT_OTHER_LOAD = rsw_pkg::cnt_t'(rsw_pkg::DRT_OTHER_CYC - 1);
    localparam rsw_pkg::cnt_t WDT_LAST      = rsw_pkg::cnt_t'(WDT_BASE_CYCLES - 1);

    logic             rst_sync1_q;
    logic             rst_sync2_q;
    rsw_pkg::pins_s   pins_raw;
    rsw_pkg::pins_s   pins_meta_q;
    rsw_pkg::pins_s   pins_q;
    rsw_pkg::state_e  state_q;
    rsw_pkg::state_e  state_d;
    rsw_pkg::status_s status_q;
    rsw_pkg::status_s status_d;
    rsw_pkg::option_s option_q;
    rsw_pkg::cnt_t    drt_q;
    rsw_pkg::cnt_t    wdt_q;
    rsw_pkg::ps_t     ps_q;
    logic             por_q;
    logic [3:0]       port_latch_q;
    logic             cmp_latch_q;
    logic             pin_reset;
    logic             wdt_en;
    logic             base_done;
    logic             ps_done;
    logic             wdt_expire;
    logic             wdt_clear;
    logic             wake_pin;
    logic             wake_cmp;
    logic [3:0]       wake_mask;
    logic             cmd_clear;
    logic             cmd_sleep;
    logic             hold_enter;
    logic             port_touch;
    logic [7:0]       rdata_d;

    // Reset release through two flip-flops
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            rst_sync1_q <= 1'b0;
            rst_sync2_q <= 1'b0;
        end else begin
            rst_sync1_q <= 1'b1;
            rst_sync2_q <= rst_sync1_q;
        end
    end

    assign pins_raw = '{
        reset_pin:             RESET_PIN,
        reset_pin_enable_fuse: RESET_PIN_FUSE,
        watchdog_enable_fuse:  WATCHDOG_FUSE,
        cmp_out:               CMP_OUT,
        cmp_wake_en:           CMP_WAKE_EN,
        port:                  PORT_IN
    };

    // Pin and fuse synchroniser
    always_ff @(posedge SYS_CLK or negedge rst_sync2_q) begin
        if (!rst_sync2_q) begin
            pins_meta_q <= '0;
            pins_q      <= '0;
        end else begin
            pins_meta_q <= pins_raw;
            pins_q      <= pins_meta_q;
        end
    end

    // Reset pin acts only when its fuse is left at 1
    assign pin_reset = pins_q.reset_pin_enable_fuse && !pins_q.reset_pin; // RULE22

    assign wdt_en    = pins_q.watchdog_enable_fuse; // RULE8
    assign base_done = (wdt_q == WDT_LAST); // RULE9
    assign ps_done   = !option_q.prescaler_assign ||
                       (ps_q == ps_limit(option_q.prescaler_rate)); // RULE9
    assign wdt_expire = wdt_en && base_done && ps_done; // RULE6

    // Pin 3 only wakes when it is not the reset pin
    assign wake_mask = pins_q.reset_pin_enable_fuse ? rsw_pkg::WAKE_MASK_NOPIN
                                                    : rsw_pkg::WAKE_MASK_ALL;
    // An unread change from before sleep wakes the device at once
    assign wake_pin  = !option_q.pin_wake_enable_n &&
                       |((pins_q.port ^ port_latch_q) & wake_mask); // RULE19
    assign wake_cmp  = pins_q.cmp_wake_en && (pins_q.cmp_out != cmp_latch_q); // RULE15

    assign cmd_clear  = access(WR, ADDR, rsw_pkg::ADDR_CMD) &&
                        WDATA[rsw_pkg::CMD_CLEAR_BIT] && (state_q == rsw_pkg::ST_RUN);
    assign cmd_sleep  = access(WR, ADDR, rsw_pkg::ADDR_CMD) &&
                        WDATA[rsw_pkg::CMD_SLEEP_BIT] && (state_q == rsw_pkg::ST_RUN);
    assign port_touch = access(WR, ADDR, rsw_pkg::ADDR_PORT) ||
                        access(RD, ADDR, rsw_pkg::ADDR_PORT);

    // Sequencing and reset-cause flags
    always_comb begin
        state_d    = state_q;
        status_d   = status_q;
        hold_enter = 1'b0;
        unique case (state_q)
            rsw_pkg::ST_HOLD: begin
                if (!pin_reset && (drt_q == '0)) begin
                    state_d = rsw_pkg::ST_RUN; // RULE2
                end
            end
            rsw_pkg::ST_RUN: begin
                if (pin_reset) begin
                    state_d    = rsw_pkg::ST_HOLD; // RULE21
                    hold_enter = 1'b1;
                end else if (wdt_expire) begin
                    state_d    = rsw_pkg::ST_HOLD; // RULE6
                    hold_enter = 1'b1;
                    status_d.watchdog_expiry_flag_n = 1'b0; // RULE7
                    status_d.pin_wake_flag          = 1'b0;
                    status_d.comparator_wake_flag   = 1'b0;
                end else if (cmd_sleep) begin
                    state_d = rsw_pkg::ST_SLEEP;
                    status_d.watchdog_expiry_flag_n = 1'b1; // RULE12
                    status_d.powerdown_flag_n       = 1'b0; // RULE16
                end
            end
            rsw_pkg::ST_SLEEP: begin
                if (pin_reset || wdt_expire || wake_pin || wake_cmp) begin
                    state_d    = rsw_pkg::ST_HOLD; // RULE15
                    hold_enter = 1'b1;
                    status_d.watchdog_expiry_flag_n = 1'b1;
                    status_d.powerdown_flag_n       = 1'b0;
                    status_d.pin_wake_flag          = 1'b0;
                    status_d.comparator_wake_flag   = 1'b0;
                    if (pin_reset) begin
                        status_d.watchdog_expiry_flag_n = 1'b1;
                    end else if (wdt_expire) begin
                        status_d.watchdog_expiry_flag_n = 1'b0; // RULE7
                    end else if (wake_pin) begin
                        status_d.pin_wake_flag = 1'b1; // RULE17
                    end else begin
                        status_d.comparator_wake_flag = 1'b1; // RULE18
                    end
                end
            end
            default: begin
                state_d    = rsw_pkg::ST_HOLD;
                hold_enter = 1'b1;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge rst_sync2_q) begin
        if (!rst_sync2_q) begin
            state_q <= rsw_pkg::ST_HOLD;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge SYS_CLK or negedge rst_sync2_q) begin
        if (!rst_sync2_q) begin
            status_q <= rsw_pkg::STATUS_POR; // RULE16
        end else begin
            status_q <= status_d; // RULE21
        end
    end

    // Reset delay timer; power-on delay until the first release
    always_ff @(posedge SYS_CLK or negedge rst_sync2_q) begin
        if (!rst_sync2_q) begin
            por_q <= 1'b1;
        end else if ((state_q == rsw_pkg::ST_HOLD) && (state_d == rsw_pkg::ST_RUN)) begin
            por_q <= 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK or negedge rst_sync2_q) begin
        if (!rst_sync2_q) begin
            drt_q <= DRT_POR_LOAD; // RULE1
        end else if (state_q == rsw_pkg::ST_HOLD) begin
            if (pin_reset) begin
                drt_q <= por_q ? DRT_POR_LOAD : DRT_OTHER_LOAD; // RULE3
            end else if (drt_q != '0) begin
                drt_q <= drt_q - rsw_pkg::cnt_t'(1); // RULE1
            end
        end else if (hold_enter) begin
            drt_q <= DRT_OTHER_LOAD; // RULE4
        end
    end

    // Watchdog runs on the always-on clock, also during sleep
    assign wdt_clear = (state_q == rsw_pkg::ST_HOLD) || hold_enter || // RULE20
                       cmd_clear || cmd_sleep; // RULE10 RULE11

    always_ff @(posedge SYS_CLK or negedge rst_sync2_q) begin
        if (!rst_sync2_q) begin
            wdt_q <= '0;
            ps_q  <= '0;
        end else if (wdt_clear || !wdt_en) begin
            wdt_q <= '0;
            ps_q  <= '0;
        end else if (base_done) begin
            // Prescaler steps once per base period
            wdt_q <= '0; // RULE5
            ps_q  <= ps_done ? '0 : ps_q + rsw_pkg::ps_t'(1);
        end else begin
            wdt_q <= wdt_q + rsw_pkg::cnt_t'(1); // RULE5
        end
    end

    // Option register, back to all ones on every reset
    always_ff @(posedge SYS_CLK or negedge rst_sync2_q) begin
        if (!rst_sync2_q) begin
            option_q <= rsw_pkg::OPTION_RESET;
        end else if ((state_q == rsw_pkg::ST_HOLD) || hold_enter) begin
            // A write in the cycle a reset starts is dropped
            option_q <= rsw_pkg::OPTION_RESET;
        end else if (access(WR, ADDR, rsw_pkg::ADDR_OPTION) &&
                     (state_q == rsw_pkg::ST_RUN)) begin
            option_q <= WDATA;
        end
    end

    // Change-detect references
    always_ff @(posedge SYS_CLK or negedge rst_sync2_q) begin
        if (!rst_sync2_q) begin
            port_latch_q <= '0;
        end else if (port_touch && (state_q == rsw_pkg::ST_RUN)) begin
            port_latch_q <= pins_q.port; // RULE19
        end
    end

    always_ff @(posedge SYS_CLK or negedge rst_sync2_q) begin
        if (!rst_sync2_q) begin
            cmp_latch_q <= 1'b0;
        end else if (cmd_sleep) begin
            cmp_latch_q <= pins_q.cmp_out; // RULE18
        end
    end

    // Pin drive frozen while asleep
    always_ff @(posedge SYS_CLK or negedge rst_sync2_q) begin
        if (!rst_sync2_q) begin
            PORT_OUT  <= '0;
            PORT_OE_N <= rsw_pkg::PORT_OE_N_RESET;
        end else if (state_d != rsw_pkg::ST_SLEEP) begin
            PORT_OUT  <= CORE_OUT;
            PORT_OE_N <= CORE_OE_N;
        end // RULE13
    end

    // Core held for the whole hold state
    always_ff @(posedge SYS_CLK or negedge rst_sync2_q) begin
        if (!rst_sync2_q) begin
            CORE_RESET <= 1'b1;
        end else begin
            CORE_RESET <= (state_d == rsw_pkg::ST_HOLD); // RULE2
        end
    end

    // Oscillator driver off and sleep marker on while asleep
    always_ff @(posedge SYS_CLK or negedge rst_sync2_q) begin
        if (!rst_sync2_q) begin
            OSC_DRIVE_EN <= 1'b1;
            SLEEPING     <= 1'b0;
        end else begin
            OSC_DRIVE_EN <= (state_d != rsw_pkg::ST_SLEEP); // RULE12
            SLEEPING     <= (state_d == rsw_pkg::ST_SLEEP);
        end
    end

    // Reset pin stays an input whatever the reset cause
    always_ff @(posedge SYS_CLK or negedge rst_sync2_q) begin
        if (!rst_sync2_q) begin
            RESET_PIN_OUT  <= 1'b0;
            RESET_PIN_OE_N <= 1'b1;
        end else begin
            RESET_PIN_OUT  <= 1'b0;
            RESET_PIN_OE_N <= 1'b1; // RULE14
        end
    end

    always_ff @(posedge SYS_CLK or negedge rst_sync2_q) begin
        if (!rst_sync2_q) begin
            OPTION <= rsw_pkg::OPTION_RESET;
        end else begin
            OPTION <= option_q;
        end
    end

    // Read port: option and command read as zero
    always_comb begin
        rdata_d = 8'h00;
        if (RD) begin
            unique case (ADDR)
                rsw_pkg::ADDR_STATUS: rdata_d = status_q;
                rsw_pkg::ADDR_PORT:   rdata_d = {4'h0, pins_q.port};
                rsw_pkg::ADDR_OPTION: rdata_d = 8'h00;
                rsw_pkg::ADDR_CMD:    rdata_d = 8'h00;
            endcase
        end
    end

    // Read data lasts one cycle, then drops to zero
    always_ff @(posedge SYS_CLK or negedge rst_sync2_q) begin
        if (!rst_sync2_q) begin
            RDATA <= 8'h00;
        end else begin
            RDATA <= rdata_d;
        end
    end

endmodule

`default_nettype wire

// file: hdl/rsw_pkg.sv
`default_nettype none

package rsw_pkg;

    // Clock rate and timing figures
    localparam int unsigned CLK_HZ        = 100_000_000;
    localparam int unsigned DRT_POR_MS    = 18;
    localparam int unsigned DRT_POR_CYC   = DRT_POR_MS * (CLK_HZ / 1_000);
    localparam int unsigned DRT_OTHER_US  = 10;
    localparam int unsigned DRT_OTHER_CYC = DRT_OTHER_US * (CLK_HZ / 1_000_000);
    localparam int unsigned WDT_BASE_MS   = 18;
    localparam int unsigned WDT_BASE_CYC  = WDT_BASE_MS * (CLK_HZ / 1_000);

    typedef logic [20:0] cnt_t;
    typedef logic [6:0]  ps_t;

    // Register offsets
    localparam logic [1:0] ADDR_OPTION = 2'h0;
    localparam logic [1:0] ADDR_STATUS = 2'h1;
    localparam logic [1:0] ADDR_CMD    = 2'h2;
    localparam logic [1:0] ADDR_PORT   = 2'h3;

    // Command register bit positions
    localparam int unsigned CMD_CLEAR_BIT = 0;
    localparam int unsigned CMD_SLEEP_BIT = 1;

    // Port pins that can wake the device
    localparam logic [3:0] WAKE_MASK_ALL   = 4'hB;
    localparam logic [3:0] WAKE_MASK_NOPIN = 4'h3;

    localparam logic [7:0] OPTION_RESET = 8'hFF;
    localparam logic [7:0] STATUS_POR   = 8'h18;
    localparam logic [3:0] PORT_OE_N_RESET = 4'hF;

    typedef enum logic [1:0] {
        ST_HOLD  = 2'b00,
        ST_RUN   = 2'b01,
        ST_SLEEP = 2'b10
    } state_e;

    typedef struct packed {
        logic       pin_wake_enable_n;
        logic       weak_pullup_enable_n;
        logic       timer_clock_source;
        logic       timer_edge_select;
        logic       prescaler_assign;
        logic [2:0] prescaler_rate;
    } option_s;

    typedef struct packed {
        logic       pin_wake_flag;
        logic       comparator_wake_flag;
        logic       spare;
        logic       watchdog_expiry_flag_n;
        logic       powerdown_flag_n;
        logic [2:0] low;
    } status_s;

    typedef struct packed {
        logic       reset_pin;
        logic       reset_pin_enable_fuse;
        logic       watchdog_enable_fuse;
        logic       cmp_out;
        logic       cmp_wake_en;
        logic [3:0] port;
    } pins_s;

endpackage

`default_nettype wire

// file: verif/pin_side_model.sv
`default_nettype none

module pin_side_model (
    input  wire logic       clk,
    input  wire logic       slow,
    input  wire logic       hold_low,
    input  wire logic [3:0] pin_req,
    input  wire logic       cmp_req,
    output var  logic       reset_pin,
    output var  logic [3:0] port_pin,
    output var  logic       cmp_level
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] now_q  = 6'h20;
    logic [5:0] late_q = 6'h20;

    // Pulled-up reset pin goes high once released
    always_ff @(posedge clk) begin
        now_q  <= {~hold_low, pin_req, cmp_req};
        late_q <= now_q;
    end

    // A slow board lets each edge arrive one cycle later
    assign {reset_pin, port_pin, cmp_level} = slow ? late_q : now_q;
endmodule

`default_nettype wire

// file: verif/reset_sleep_watchdog_control_tb_top.sv
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin fail_count++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end

module reset_sleep_watchdog_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic [7:0] opt;
        int         ev;
        logic [7:0] stat;
    } row_s;
    logic             SYS_CLK = 1'b0;
    logic             RSTN = 1'b0;
    logic             WR = 1'b0;
    logic             RD = 1'b0;
    logic [1:0]       ADDR = 2'h0;
    logic [7:0]       WDATA = 8'h00;
    logic             RESET_PIN_FUSE = 1'b1;
    logic             WATCHDOG_FUSE = 1'b1;
    logic             CMP_WAKE_EN = 1'b1;
    logic [3:0]       CORE_OUT = 4'h0;
    logic [3:0]       CORE_OE_N = 4'hF;
    logic             rst_low_req = 1'b0;
    logic             cmp_req = 1'b0;
    logic             slow = 1'b0;
    logic [3:0]       pin_req = 4'h0;
    logic [7:0]       RDATA;
    logic [3:0]       PORT_IN, PORT_OUT, PORT_OE_N;
    logic             RESET_PIN, RESET_PIN_OUT, RESET_PIN_OE_N, CMP_OUT;
    logic             CORE_RESET, OSC_DRIVE_EN, SLEEPING;
    rsw_pkg::option_s OPTION;
    int               fail_count = 0;
    int               checked = 0;
    int               cycles = 0;
    int               n;
    logic [7:0]       d;
    // Events: 0/1 pin, 2 comparator, 3 reset pin, 4/5 watchdog, 6 unread pin
    row_s rows[7] = '{'{8'h7F, 0, 8'h90}, '{8'h7F, 1, 8'h90}, '{8'h7F, 2, 8'h50},
        '{8'h7F, 3, 8'h10}, '{8'hF8, 4, 8'h00}, '{8'hF0, 5, 8'h00}, '{8'h7F, 6, 8'h90}};

    reset_sleep_watchdog_control #(.DRT_POR_CYCLES(200), .WDT_BASE_CYCLES(50))
    reset_sleep_watchdog_control_inst (
        .SYS_CLK, .RSTN, .ADDR, .WDATA, .WR, .RD, .RDATA, .RESET_PIN, .RESET_PIN_OUT,
        .RESET_PIN_OE_N, .RESET_PIN_FUSE, .WATCHDOG_FUSE, .PORT_IN, .CMP_OUT, .CMP_WAKE_EN,
        .CORE_OUT, .CORE_OE_N, .PORT_OUT, .PORT_OE_N, .CORE_RESET, .OSC_DRIVE_EN,
        .SLEEPING, .OPTION
    );

    pin_side_model pin_side_model_inst (
        .clk(SYS_CLK), .slow(slow), .hold_low(rst_low_req), .pin_req(pin_req),
        .cmp_req(cmp_req), .reset_pin(RESET_PIN), .port_pin(PORT_IN), .cmp_level(CMP_OUT)
    );

    always #5 SYS_CLK = ~SYS_CLK;

    always @(posedge SYS_CLK) begin
        cycles++;
        if (cycles == 40000) begin
            fail_count++;
            results();
        end
    end

    task automatic cyc(input int k);
        repeat (k) @(posedge SYS_CLK);
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] v);
        @(posedge SYS_CLK);
        ADDR <= a;
        WDATA <= v;
        WR <= 1'b1;
        @(posedge SYS_CLK);
        WR <= 1'b0;
    endtask

    task automatic rd(input logic [1:0] a, output logic [7:0] v);
        @(posedge SYS_CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge SYS_CLK);
        RD <= 1'b0;
        @(negedge SYS_CLK);
        v = RDATA;
    endtask

    task automatic wait_core(input logic lvl, input int lim);
        n = 0;
        @(negedge SYS_CLK);
        while (CORE_RESET !== lvl && n < lim) begin
            @(negedge SYS_CLK);
            n++;
        end
        `CHK("core_reset", lvl, CORE_RESET)
    endtask

    task automatic por();
        @(posedge SYS_CLK);
        RSTN <= 1'b0;
        cyc(3);
        RSTN <= 1'b1;
        wait_core(1'b0, 400);
        `CHK("por_delay", 1'b1, n >= 200 && n <= 208)
        rd(rsw_pkg::ADDR_STATUS, d);
        `CHK("por_status", 8'h18, d)
    endtask

    task automatic results();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        por();
        rd(rsw_pkg::ADDR_OPTION, d);
        `CHK("option_read", 8'h00, d)
        foreach (rows[i]) begin
            cyc(1);
            slow <= i[0];
            RESET_PIN_FUSE <= (rows[i].ev != 6);
            CMP_WAKE_EN <= (rows[i].ev != 4);
            CORE_OUT <= 4'(i);
            CORE_OE_N <= ~4'(i);
            rd(rsw_pkg::ADDR_PORT, d);
            `CHK("port_read", {4'h0, pin_req}, d)
            wr(rsw_pkg::ADDR_OPTION, rows[i].opt);
            if (rows[i].ev == 6) pin_req[3] <= ~pin_req[3];
            if (rows[i].ev != 5) wr(rsw_pkg::ADDR_CMD, 8'h02);
            if (rows[i].ev < 5) begin
                @(negedge SYS_CLK);
                `CHK("sleeping", 1'b1, SLEEPING)
                `CHK("osc_drive", 1'b0, OSC_DRIVE_EN)
                `CHK("option_out", rows[i].opt, OPTION)
                cyc(1);
                CORE_OUT <= ~4'(i);
                CORE_OE_N <= 4'(i);
                cyc(3);
                @(negedge SYS_CLK);
                `CHK("port_out", 4'(i), PORT_OUT)
                `CHK("port_oe_n", ~4'(i), PORT_OE_N)
                cyc(1);
            end
            case (rows[i].ev)
                0: pin_req[0] <= ~pin_req[0];
                1: pin_req[1] <= ~pin_req[1];
                2, 4: cmp_req <= ~cmp_req;
                3: begin
                    rst_low_req <= 1'b1;
                    cyc(6);
                    rst_low_req <= 1'b0;
                end
                default: ;
            endcase
            wait_core(1'b1, 8000);
            wait_core(1'b0, 3000);
            rd(rsw_pkg::ADDR_STATUS, d);
            `CHK("wake_status", rows[i].stat, d)
            `CHK("pin_oe_n", 1'b1, RESET_PIN_OE_N)
            `CHK("pin_out", 1'b0, RESET_PIN_OUT)
        end
        wr(rsw_pkg::ADDR_CMD, 8'h01);
        wr(rsw_pkg::ADDR_OPTION, 8'hF0);
        repeat (6) begin
            cyc(30);
            wr(rsw_pkg::ADDR_CMD, 8'h01);
        end
        @(negedge SYS_CLK);
        `CHK("clear_no_reset", 1'b0, CORE_RESET)
        cyc(1);
        WATCHDOG_FUSE <= 1'b0;
        cyc(200);
        @(negedge SYS_CLK);
        `CHK("fuse_off", 1'b0, CORE_RESET)
        cyc(1);
        RESET_PIN_FUSE <= 1'b1;
        rst_low_req <= 1'b1;
        cyc(6);
        rst_low_req <= 1'b0;
        WATCHDOG_FUSE <= 1'b1;
        wait_core(1'b1, 20);
        wait_core(1'b0, 3000);
        rd(rsw_pkg::ADDR_STATUS, d);
        `CHK("flags_kept", 8'h90, d)
        por();
        results();
    end
endmodule

`default_nettype wire

// file: verif/rsw_properties.sv
`default_nettype none

module rsw_checker (
    input wire logic             SYS_CLK,
    input wire logic             RSTN,
    input wire logic             RD,
    input wire logic             WR,
    input wire logic [1:0]       ADDR,
    input wire logic [7:0]       WDATA,
    input wire logic [7:0]       RDATA,
    input wire logic             RESET_PIN,
    input wire logic             RESET_PIN_OE_N,
    input wire logic [3:0]       PORT_OUT,
    input wire logic [3:0]       PORT_OE_N,
    input wire logic             CORE_RESET,
    input wire logic             OSC_DRIVE_EN,
    input wire logic             SLEEPING,
    input wire rsw_pkg::option_s OPTION
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RSTN);

    localparam logic [10:0] WAKE_LO = 11'h3E2;
    localparam logic [10:0] WAKE_HI = 11'h3EC;
    logic                   woke_q;
    logic [10:0]            wake_cnt_q;

    // Cycles from a sleep exit with the pin high until the core is let go
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            woke_q     <= 1'b0;
            wake_cnt_q <= 11'h000;
        end else if ($fell(SLEEPING) && RESET_PIN) begin
            woke_q     <= 1'b1;
            wake_cnt_q <= 11'h000;
        end else if (woke_q && !CORE_RESET) begin
            woke_q <= 1'b0;
        end else if (woke_q && (wake_cnt_q != 11'h7FF)) begin
            wake_cnt_q <= wake_cnt_q + 11'h001;
        end
    end

    chk_pin_not_driven: assert property (RESET_PIN_OE_N)
        else $error("reset pin driven");
    chk_sleep_osc_off: assert property (SLEEPING |-> !OSC_DRIVE_EN)
        else $error("oscillator on in sleep");
    chk_sleep_entry: assert property (WR && ADDR == 2'h2 && WDATA[1] && !CORE_RESET
        && !SLEEPING |=> SLEEPING && !OSC_DRIVE_EN) else $error("sleep not entered");
    chk_port_frozen: assert property (SLEEPING && $past(SLEEPING)
        |-> $stable(PORT_OUT) && $stable(PORT_OE_N)) else $error("port moved in sleep");
    chk_core_hold_min: assert property ($rose(CORE_RESET) |=> CORE_RESET[*8])
        else $error("core reset too short");
    chk_wake_resets: assert property ($fell(SLEEPING) |-> CORE_RESET)
        else $error("wake without core reset");
    chk_short_delay: assert property (woke_q && $fell(CORE_RESET)
        |-> (wake_cnt_q >= WAKE_LO) && (wake_cnt_q <= WAKE_HI))
        else $error("wake delay wrong");
    chk_option_reset: assert property (CORE_RESET && $past(CORE_RESET)
        |-> OPTION == 8'hFF) else $error("option not at reset value");
    chk_rdata_idle: assert property (!$past(RD) |-> RDATA == 8'h00)
        else $error("read data outside read slot");
endmodule

bind reset_sleep_watchdog_control rsw_checker rsw_checker_inst (
    .SYS_CLK, .RSTN, .RD, .WR, .ADDR, .WDATA, .RDATA, .RESET_PIN, .RESET_PIN_OE_N,
    .PORT_OUT, .PORT_OE_N, .CORE_RESET, .OSC_DRIVE_EN, .SLEEPING, .OPTION
);

`default_nettype wire
